// *** rtl/dhl_defs.svh ***
// Offsets, codes, versions, limits and timing counts of the health log formatter
`ifndef DHL_DEFS_SVH
`define DHL_DEFS_SVH
// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define DHL_CLK_NS          10
`define DHL_MS_NS           1000000
`define DHL_MS_CYCLES       (`DHL_MS_NS / `DHL_CLK_NS)
// ---------------------------------------------------------------
// Geometry
// ---------------------------------------------------------------
`define DHL_SECTOR_LAST     9'h1ff
`define DHL_HIST_DEPTH      5
`define DHL_ENT_BASE        2
`define DHL_ENT_LEN         90
`define DHL_CMD_LEN         12
`define DHL_ERR_OFS         60
`define DHL_ERR_STATE_OFS   27
`define DHL_ERR_HOUR_OFS    28
`define DHL_ERR_VER_OFS     9'h000
`define DHL_ERR_PTR_OFS     9'h001
`define DHL_ERR_CNT_OFS     9'h1c4
`define DHL_ST_DESC_NUM     21
`define DHL_ST_DESC_LEN     24
`define DHL_ST_BASE         2
`define DHL_ST_USED_LEN     9
`define DHL_ST_PTR_OFS      9'h1fc
// ---------------------------------------------------------------
// Values
// ---------------------------------------------------------------
`define DHL_ERR_LOG_VER     8'h01
`define DHL_ST_REV          16'h0001
`define DHL_ERR_CNT_MAX     16'hffff
`define DHL_CMD_SMART       8'hb0
`define DHL_KEY_CYL_LO      8'h4f
`define DHL_KEY_CYL_HI      8'hc2
`define DHL_SUB_RD_VALUES   8'hd0
`define DHL_SUB_RD_THRESH   8'hd1
`define DHL_SUB_SAVE        8'hd3
`define DHL_SUB_GAP         8'hd7
`define DHL_SUB_ENABLE      8'hd8
`define DHL_SUB_DISABLE     8'hd9
`define DHL_SUB_MAX         8'hda
`define DHL_STAT_FAIL       8'h51
`define DHL_STAT_OK         8'h50
`define DHL_ERR_ABORT       8'h04
`define DHL_ERR_RD_FAULT    8'h40
`define DHL_ERR_WR_FAULT    8'h01
`define DHL_ERR_NONE        8'h00
`endif

// *** rtl/dhl_pkg.sv ***
// Types shared by the health log formatter modules
`default_nettype none
package dhl_pkg;
  // Device state code, low nibble of the error snapshot state byte
  typedef enum logic [3:0] {
    DHL_ST_UNKNOWN = 4'h0,
    DHL_ST_SLEEP   = 4'h1,
    DHL_ST_STANDBY = 4'h2,
    DHL_ST_ACTIVE  = 4'h3,
    DHL_ST_OFFLINE = 4'h4
  } dhl_state_t;
  // Which sector is streamed
  typedef enum logic {
    DHL_LOG_SUMMARY  = 1'b0,
    DHL_LOG_SELFTEST = 1'b1
  } dhl_log_t;
  // Stream sequencer
  typedef enum logic {
    DHL_IDLE = 1'b0,
    DHL_RUN  = 1'b1
  } dhl_fsm_t;
  // Twelve command snapshot bytes, byte k in bits 8k+7:8k
  typedef logic [95:0] dhl_snap_t;
endpackage
`default_nettype wire

// *** rtl/dhl_sec_if.sv ***
// Byte lookup link between the sector streamer and the log storage
`timescale 1ns/1ps
`default_nettype none
interface dhl_sec_if;
  dhl_pkg::dhl_log_t sel;
  logic [8:0]        addr;
  logic [7:0]        data;
  modport store  (input sel, input addr, output data);
  modport stream (output sel, output addr, input data);
endinterface
`default_nettype wire

// *** rtl/dhl_sector_stream.sv ***
// Streams one 512-byte log sector and closes it with the checksum byte
`timescale 1ns/1ps
`default_nettype none
`include "dhl_defs.svh"
module dhl_sector_stream
(
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        reset,
  // Reader side
  input  wire logic        rd_start,
  input  wire logic        rd_sel,
  input  wire logic        rd_take,
  output logic             rd_valid,
  output logic [7:0]       rd_data,
  output logic             rd_last,
  // Storage lookup
  dhl_sec_if.stream        sec
);
  dhl_pkg::dhl_fsm_t fsm_reg;
  dhl_pkg::dhl_log_t sel_reg;
  logic [8:0]        idx_reg;
  logic [7:0]        sum_reg;
  logic              load;

  assign sec.sel  = sel_reg;
  assign sec.addr = idx_reg;
  // Next byte loads when the holding flop is empty or being drained
  assign load = (fsm_reg == dhl_pkg::DHL_RUN) && (!rd_valid || rd_take);

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      fsm_reg <= dhl_pkg::DHL_IDLE;
      sel_reg <= dhl_pkg::DHL_LOG_SUMMARY;
      idx_reg <= 9'h000;
    end
    else if (rd_start)
    begin
      fsm_reg <= dhl_pkg::DHL_RUN;
      sel_reg <= dhl_pkg::dhl_log_t'(rd_sel);
      idx_reg <= 9'h000;
    end
    else if (load)
    begin
      idx_reg <= idx_reg + 9'h001;
      if (idx_reg == `DHL_SECTOR_LAST)
        fsm_reg <= dhl_pkg::DHL_IDLE;
    end
  end

  // Running sum; the last byte is its negation so the sector sums to zero
  always_ff @(posedge sys_clk)
  begin
    if (reset || rd_start)
      sum_reg <= 8'h00;
    else if (load)
      sum_reg <= sum_reg + sec.data;
  end

  // Output holding flop
  always_ff @(posedge sys_clk)
  begin
    if (reset || rd_start)
    begin
      rd_valid <= 1'b0;
      rd_data  <= 8'h00;
      rd_last  <= 1'b0;
    end
    else if (load)
    begin
      rd_valid <= 1'b1;
      rd_last  <= (idx_reg == `DHL_SECTOR_LAST);
      rd_data  <= (idx_reg == `DHL_SECTOR_LAST) ? (8'h00 - sum_reg) : sec.data;
    end
    else if (rd_take)
    begin
      rd_valid <= 1'b0;
      rd_last  <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// *** rtl/dhl_formatter.sv ***
// Health log formatter: command history, error and self-test logs, command replies
`timescale 1ns/1ps
`default_nettype none
`include "dhl_defs.svh"
module dhl_formatter
#(
  parameter int unsigned MS_CYCLES = `DHL_MS_CYCLES
)
(
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        reset,
  // Task-file command capture
  input  wire logic        cmd_valid,
  input  wire logic [7:0]  cmd_devctl,
  input  wire logic [7:0]  cmd_feat,
  input  wire logic [7:0]  cmd_seccnt,
  input  wire logic [7:0]  cmd_secnum,
  input  wire logic [7:0]  cmd_cyllo,
  input  wire logic [7:0]  cmd_cylhi,
  input  wire logic [7:0]  cmd_devhead,
  input  wire logic [7:0]  cmd_code,
  input  wire logic [3:0]  dev_state,
  // Error event with returned registers
  input  wire logic        err_valid,
  input  wire logic [7:0]  err_error,
  input  wire logic [7:0]  err_seccnt,
  input  wire logic [7:0]  err_secnum,
  input  wire logic [7:0]  err_cyllo,
  input  wire logic [7:0]  err_cylhi,
  input  wire logic [7:0]  err_devhead,
  input  wire logic [7:0]  err_status,
  input  wire logic [15:0] power_on_hours,
  // Self-test result
  input  wire logic        st_valid,
  input  wire logic [7:0]  st_number,
  input  wire logic [7:0]  st_status,
  input  wire logic [7:0]  st_checkpoint,
  input  wire logic [31:0] st_lba,
  // Attribute store faults
  input  wire logic        attr_rd_fail,
  input  wire logic        attr_wr_fail,
  // Health command reply
  output logic             smart_done,
  output logic [7:0]       smart_status,
  output logic [7:0]       smart_error,
  output logic             smart_enabled,
  // Sector read stream
  input  wire logic        rd_start,
  input  wire logic        rd_sel,
  input  wire logic        rd_take,
  output logic             rd_valid,
  output logic [7:0]       rd_data,
  output logic             rd_last
);
  dhl_sec_if sec ();

  dhl_pkg::dhl_snap_t hist_reg [0:4];
  dhl_pkg::dhl_snap_t ent_cmd_reg [0:4][0:4];
  logic [239:0]       ent_err_reg [0:4];
  logic [71:0]        st_desc_reg [0:20];
  logic [2:0]         err_ptr_reg;
  logic [15:0]        err_cnt_reg;
  logic [4:0]         st_ptr_reg;
  logic [31:0]        ms_reg;
  logic [31:0]        ms_div_reg;
  logic [3:0]         state_reg;
  logic [2:0]         err_slot;
  logic [4:0]         st_slot;
  logic [239:0]       err_snap;
  logic [7:0]         byte_val;
  dhl_pkg::dhl_state_t state_code;

  // ---------------------------------------------------------------
  // Power-on millisecond time base
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (reset || (ms_div_reg == MS_CYCLES - 1))
      ms_div_reg <= 32'h0000_0000;
    else
      ms_div_reg <= ms_div_reg + 32'h0000_0001;
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
      ms_reg <= 32'h0000_0000;
    else if (ms_div_reg == MS_CYCLES - 1)
      ms_reg <= ms_reg + 32'h0000_0001;
  end

  // ---------------------------------------------------------------
  // Command history, newest in slot 4
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      for (int i = 0; i < `DHL_HIST_DEPTH; i++)
        hist_reg[i] <= '0;
      state_reg <= 4'h0;
    end
    else if (cmd_valid)
    begin
      for (int i = 0; i < `DHL_HIST_DEPTH - 1; i++)
        hist_reg[i] <= hist_reg[i+1];
      hist_reg[4] <= {ms_reg, cmd_code, cmd_devhead, cmd_cylhi, cmd_cyllo,
                      cmd_secnum, cmd_seccnt, cmd_feat, cmd_devctl};
      state_reg   <= dev_state;
    end
  end

  // Codes outside the defined set fall back to unknown; upper nibble stays zero
  always_comb
  begin
    if (state_reg <= 4'h4)
      state_code = dhl_pkg::dhl_state_t'(state_reg);
    else
      state_code = dhl_pkg::DHL_ST_UNKNOWN;
  end

  // Error snapshot: byte 0 and vendor bytes 8..26 zero, hours low byte first
  assign err_snap = {power_on_hours, 4'h0, state_code, 152'h0,
                     err_status, err_devhead, err_cylhi, err_cyllo,
                     err_secnum, err_seccnt, err_error, 8'h00};

  // ---------------------------------------------------------------
  // Summary error log
  // ---------------------------------------------------------------
  assign err_slot = (err_ptr_reg == 3'd5 || err_ptr_reg == 3'd0) ? 3'd0 : err_ptr_reg;

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      err_ptr_reg <= 3'd0;
      err_cnt_reg <= 16'h0000;
      for (int e = 0; e < 5; e++)
      begin
        ent_err_reg[e] <= '0;
        for (int c = 0; c < 5; c++)
          ent_cmd_reg[e][c] <= '0;
      end
    end
    else if (err_valid)
    begin
      for (int c = 0; c < 5; c++)
        ent_cmd_reg[err_slot][c] <= hist_reg[c];
      ent_err_reg[err_slot] <= err_snap;
      err_ptr_reg <= err_slot + 3'd1;
      if (err_cnt_reg != `DHL_ERR_CNT_MAX)
        err_cnt_reg <= err_cnt_reg + 16'h0001;  // Count saturates, never rolls over
    end
  end

  // ---------------------------------------------------------------
  // Self-test log ring
  // ---------------------------------------------------------------
  assign st_slot = (st_ptr_reg == 5'd21) ? 5'd0 : st_ptr_reg;

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      st_ptr_reg <= 5'd0;
      for (int n = 0; n < `DHL_ST_DESC_NUM; n++)
        st_desc_reg[n] <= '0;
    end
    else if (st_valid)
    begin
      st_desc_reg[st_slot] <= {st_lba, st_checkpoint, power_on_hours, st_status, st_number};
      st_ptr_reg <= st_slot + 5'd1;
    end
  end

  // ---------------------------------------------------------------
  // Byte lookup for the streamer
  // ---------------------------------------------------------------
  // Pure decode from stored fields; a log event during a read shows in later bytes
  always_comb
  begin
    int a;
    int off;
    a        = int'(sec.addr);
    off      = 0;
    byte_val = 8'h00;
    if (sec.sel == dhl_pkg::DHL_LOG_SUMMARY)
    begin
      if (sec.addr == `DHL_ERR_VER_OFS)
        byte_val = `DHL_ERR_LOG_VER;
      else if (sec.addr == `DHL_ERR_PTR_OFS)
        byte_val = {5'h00, err_ptr_reg};
      else if (sec.addr == `DHL_ERR_CNT_OFS)
        byte_val = err_cnt_reg[7:0];
      else if (sec.addr == `DHL_ERR_CNT_OFS + 9'h001)
        byte_val = err_cnt_reg[15:8];
      for (int e = 0; e < 5; e++)
      begin
        if (a >= `DHL_ENT_BASE + e * `DHL_ENT_LEN && a < `DHL_ENT_BASE + (e + 1) * `DHL_ENT_LEN)
        begin
          off = a - `DHL_ENT_BASE - e * `DHL_ENT_LEN;
          if (off < `DHL_ERR_OFS)
            byte_val = ent_cmd_reg[e][off / `DHL_CMD_LEN][8 * (off % `DHL_CMD_LEN) +: 8];
          else
            byte_val = ent_err_reg[e][8 * (off - `DHL_ERR_OFS) +: 8];
        end
      end
    end
    else
    begin
      if (sec.addr == 9'h000)
        byte_val = 8'(`DHL_ST_REV & 16'h00ff);
      else if (sec.addr == 9'h001)
        byte_val = 8'(`DHL_ST_REV >> 8);
      else if (sec.addr == `DHL_ST_PTR_OFS)
        byte_val = {3'h0, st_ptr_reg};
      for (int n = 0; n < `DHL_ST_DESC_NUM; n++)
      begin
        off = a - `DHL_ST_BASE - n * `DHL_ST_DESC_LEN;
        if (off >= 0 && off < `DHL_ST_USED_LEN)
          byte_val = st_desc_reg[n][8 * off +: 8];
      end
    end
  end

  assign sec.data = byte_val;

  // ---------------------------------------------------------------
  // Health command checks and reply
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      smart_done    <= 1'b0;
      smart_status  <= 8'h00;
      smart_error   <= 8'h00;
      smart_enabled <= 1'b1;
    end
    else
    begin
      smart_done <= 1'b0;
      if (cmd_valid && cmd_code == `DHL_CMD_SMART)
      begin
        smart_done   <= 1'b1;
        smart_status <= `DHL_STAT_FAIL;
        smart_error  <= `DHL_ERR_ABORT;
        // Key is checked first so a stray command never flips the enable
        if (cmd_cyllo != `DHL_KEY_CYL_LO || cmd_cylhi != `DHL_KEY_CYL_HI)
          smart_error <= `DHL_ERR_ABORT;
        else if (!smart_enabled && cmd_feat != `DHL_SUB_ENABLE)
          smart_error <= `DHL_ERR_ABORT;
        else if (cmd_feat < `DHL_SUB_RD_VALUES || cmd_feat > `DHL_SUB_MAX || cmd_feat == `DHL_SUB_GAP)
          smart_error <= `DHL_ERR_ABORT;
        else if (attr_rd_fail && (cmd_feat == `DHL_SUB_RD_VALUES || cmd_feat == `DHL_SUB_RD_THRESH))
          smart_error <= `DHL_ERR_RD_FAULT;
        else if (attr_wr_fail && cmd_feat == `DHL_SUB_SAVE)
          smart_error <= `DHL_ERR_WR_FAULT;
        else
        begin
          smart_status <= `DHL_STAT_OK;
          smart_error  <= `DHL_ERR_NONE;
          if (cmd_feat == `DHL_SUB_ENABLE)
            smart_enabled <= 1'b1;
          else if (cmd_feat == `DHL_SUB_DISABLE)
            smart_enabled <= 1'b0;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Sector streamer
  // ---------------------------------------------------------------
  dhl_sector_stream u_stream
  (
    .sys_clk  (sys_clk),
    .reset    (reset),
    .rd_start (rd_start),
    .rd_sel   (rd_sel),
    .rd_take  (rd_take),
    .rd_valid (rd_valid),
    .rd_data  (rd_data),
    .rd_last  (rd_last),
    .sec      (sec.stream)
  );
endmodule
`default_nettype wire

// *** sim/dhl_formatter_monitor.sv ***
// Concurrent checks of the health log formatter reply and sector stream
`timescale 1ns/1ps
`default_nettype none
module dhl_formatter_monitor
(
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       reset,
  // Command capture
  input  wire logic       cmd_valid,
  input  wire logic [7:0] cmd_feat,
  input  wire logic [7:0] cmd_cyllo,
  input  wire logic [7:0] cmd_cylhi,
  input  wire logic [7:0] cmd_code,
  input  wire logic       attr_rd_fail,
  input  wire logic       attr_wr_fail,
  // Reply
  input  wire logic       smart_done,
  input  wire logic [7:0] smart_status,
  input  wire logic [7:0] smart_error,
  input  wire logic       smart_enabled,
  // Sector stream
  input  wire logic       rd_start,
  input  wire logic       rd_take,
  input  wire logic       rd_valid,
  input  wire logic [7:0] rd_data,
  input  wire logic       rd_last
);
  logic       hc;
  logic       key_ok;
  logic       bad_sub;
  logic [7:0] sum_reg;
  logic [9:0] cnt_reg;
  // Decode of a health command as it is taken
  assign hc      = cmd_valid && cmd_code == 8'hb0;
  assign key_ok  = cmd_cyllo == 8'h4f && cmd_cylhi == 8'hc2;
  assign bad_sub = cmd_feat < 8'hd0 || cmd_feat > 8'hda || cmd_feat == 8'hd7;
  // Sum and count of bytes handed over, so the checksum is judged on what the reader saw
  always_ff @(posedge sys_clk)
  begin
    if (reset || rd_start)
    begin
      sum_reg <= 8'h00;
      cnt_reg <= 10'h000;
    end
    else if (rd_valid && rd_take)
    begin
      sum_reg <= sum_reg + rd_data;
      cnt_reg <= cnt_reg + 10'h001;
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  chk_done_latency: assert property (hc |=> smart_done) else $error("reply pulse missing");
  chk_reply_hold: assert property (!hc |=> !smart_done && $stable(smart_status)
    && $stable(smart_error) && $stable(smart_enabled)) else $error("reply changed without command");
  chk_key_refuse: assert property (hc && !key_ok |=> smart_status == 8'h51 && smart_error == 8'h04)
    else $error("missing key not refused");
  chk_off_refuse: assert property (hc && key_ok && !smart_enabled && cmd_feat != 8'hd8
    |=> smart_status == 8'h51 && smart_error == 8'h04 && !smart_enabled) else $error("disabled not refused");
  chk_bad_sub: assert property (hc && key_ok && smart_enabled && bad_sub
    |=> smart_status == 8'h51 && smart_error == 8'h04) else $error("bad subcommand not refused");
  chk_read_fault: assert property (hc && key_ok && smart_enabled && attr_rd_fail
    && cmd_feat inside {8'hd0, 8'hd1} |=> smart_status == 8'h51 && smart_error == 8'h40) else $error("read fault");
  chk_write_fault: assert property (hc && key_ok && smart_enabled && attr_wr_fail && cmd_feat == 8'hd3
    |=> smart_status == 8'h51 && smart_error == 8'h01) else $error("write fault");
  chk_enable_cmd: assert property (hc && key_ok && cmd_feat == 8'hd8
    |=> smart_enabled && smart_status == 8'h50) else $error("enable failed");
  chk_sector_sum: assert property (rd_valid && rd_last |-> sum_reg + rd_data == 8'h00)
    else $error("sector does not sum to zero");
  chk_last_byte: assert property (rd_valid && rd_last |-> cnt_reg == 10'd511) else $error("last byte misplaced");
  chk_stream_start: assert property (rd_start |=> !rd_valid ##1 rd_valid) else $error("stream start");
endmodule
bind dhl_formatter dhl_formatter_monitor i_mon (.sys_clk, .reset, .cmd_valid, .cmd_feat, .cmd_cyllo, .cmd_cylhi,
  .cmd_code, .attr_rd_fail, .attr_wr_fail, .smart_done, .smart_status, .smart_error, .smart_enabled, .rd_start,
  .rd_take, .rd_valid, .rd_data, .rd_last);
`default_nettype wire

// *** sim/dhl_host_model.sv ***
// Host side reader that pulls one log sector out of the streamer
`timescale 1ns/1ps
`default_nettype none
module dhl_host_model
(
  // Clock
  input  wire logic       sys_clk,
  // Stream request
  output logic            rd_start,
  output logic            rd_sel,
  output logic            rd_take,
  // Stream data
  input  wire logic       rd_valid,
  input  wire logic [7:0] rd_data,
  input  wire logic       rd_last
);
  logic [7:0] sec [0:511];
  int         got;
  int         last_at;
  // Idle until asked
  initial
  begin
    rd_start = 1'b0;
    rd_sel   = 1'b0;
    rd_take  = 1'b0;
  end
  // A slow reader takes every other cycle so the streamer must hold its byte
  task automatic read_sector(input logic sel, input bit slow);
    int n;
    got     = 0;
    n       = 0;
    last_at = -1;
    @(posedge sys_clk);
    rd_start <= 1'b1;
    rd_sel   <= sel;
    @(posedge sys_clk);
    rd_start <= 1'b0;
    while (got < 512 && n < 3000)
    begin
      @(posedge sys_clk);
      if (rd_valid && rd_take)
      begin
        if (rd_last)
          last_at = got;
        sec[got] = rd_data;
        got++;
      end
      rd_take <= (got < 512) && (slow ? ~rd_take : 1'b1);
      n++;
    end
  endtask
endmodule
`default_nettype wire

// *** sim/dhl_formatter_tb.sv ***
// Self-checking bench of the health log formatter
`timescale 1ns/1ps
`default_nettype none
module dhl_formatter_tb;
  typedef struct packed {logic [7:0] feat; logic kb, rf, wf; logic [7:0] st, er; logic en;} dhl_row_t;
  logic        sys_clk = 1'b0;
  logic        reset;
  logic        cmd_valid, err_valid, st_valid, attr_rd_fail, attr_wr_fail;
  logic [7:0]  cmd_devctl, cmd_feat, cmd_seccnt, cmd_secnum, cmd_cyllo, cmd_cylhi, cmd_devhead, cmd_code;
  logic [7:0]  err_error, err_seccnt, err_secnum, err_cyllo, err_cylhi, err_devhead, err_status;
  logic [7:0]  st_number, st_status, st_checkpoint;
  logic [3:0]  dev_state;
  logic [15:0] power_on_hours;
  logic [31:0] st_lba;
  logic        smart_done, smart_enabled, rd_start, rd_sel, rd_take, rd_valid, rd_last;
  logic [7:0]  smart_status, smart_error, rd_data;
  logic [7:0]  s;
  logic [3:0]  sts [7] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'hb};
  int          err_count, checked, base;
  // Health commands: subcommand, bad key, faults, then the reply they should give
  dhl_row_t rows [17] = '{'{8'hd0,0,0,0,8'h50,8'h00,1}, '{8'hd0,1,0,0,8'h51,8'h04,1}, '{8'hc0,0,0,0,8'h51,8'h04,1},
    '{8'hd7,0,0,0,8'h51,8'h04,1}, '{8'hdb,0,0,0,8'h51,8'h04,1}, '{8'hda,0,0,0,8'h50,8'h00,1},
    '{8'hd0,0,1,0,8'h51,8'h40,1}, '{8'hd1,0,1,0,8'h51,8'h40,1}, '{8'hd3,0,0,1,8'h51,8'h01,1},
    '{8'hd3,0,0,0,8'h50,8'h00,1}, '{8'hd9,0,0,0,8'h50,8'h00,0}, '{8'hd0,0,0,0,8'h51,8'h04,0},
    '{8'hd3,0,0,1,8'h51,8'h04,0}, '{8'hd9,1,0,0,8'h51,8'h04,0}, '{8'hd8,0,0,0,8'h50,8'h00,1},
    '{8'hd2,0,0,0,8'h50,8'h00,1}, '{8'hd9,0,0,0,8'h50,8'h00,0}};
  // Short count so the millisecond stamps move within a few cycles
  dhl_formatter #(.MS_CYCLES(4)) i_dut (.sys_clk, .reset, .cmd_valid, .cmd_devctl, .cmd_feat, .cmd_seccnt,
    .cmd_secnum, .cmd_cyllo, .cmd_cylhi, .cmd_devhead, .cmd_code, .dev_state, .err_valid, .err_error, .err_seccnt,
    .err_secnum, .err_cyllo, .err_cylhi, .err_devhead, .err_status, .power_on_hours, .st_valid, .st_number,
    .st_status, .st_checkpoint, .st_lba, .attr_rd_fail, .attr_wr_fail, .smart_done, .smart_status, .smart_error,
    .smart_enabled, .rd_start, .rd_sel, .rd_take, .rd_valid, .rd_data, .rd_last);
  dhl_host_model i_host (.sys_clk, .rd_start, .rd_sel, .rd_take, .rd_valid, .rd_data, .rd_last);
  // Free running clock
  always #5 sys_clk = ~sys_clk;
  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      err_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  function automatic logic [7:0] cb(int k, int b);
    if (k < 0)
      return 8'h00;
    return (b == 7) ? 8'hc8 : 8'(16 * b + k);
  endfunction
  function automatic logic [63:0] creg(int k);
    logic [63:0] r;
    for (int b = 0; b < 8; b++)
      r[63 - 8 * b -: 8] = cb(k, b);
    return r;
  endfunction
  function automatic logic [7:0] es(int k, int b);
    if (b == 0 || (b > 7 && b < 27))
      return 8'h00;
    if (b < 8)
      return 8'(16 * b + k);
    if (b == 27)
      return 8'((k < 5) ? k : 0);
    return (b == 28) ? 8'(8'h34 + k) : 8'h12;
  endfunction
  function automatic logic [7:0] sd(int t, int b);
    case (b)
      0: return 8'(t + 1);
      1: return 8'(8'h10 + t);
      2, 5: return 8'(t);
      3: return 8'h01;
      4: return 8'(8'h80 + t);
      6: return 8'h0c;
      7: return 8'h0b;
      8: return 8'h0a;
      default: return 8'h00;
    endcase
  endfunction
  function automatic logic [31:0] ms_at(int a);
    return {i_host.sec[a + 3], i_host.sec[a + 2], i_host.sec[a + 1], i_host.sec[a]};
  endfunction
  task automatic send_cmd(input logic [63:0] regs, input logic [3:0] st, input logic rf, input logic wf);
    @(posedge sys_clk);
    cmd_valid <= 1'b1;
    {cmd_devctl, cmd_feat, cmd_seccnt, cmd_secnum, cmd_cyllo, cmd_cylhi, cmd_devhead, cmd_code} <= regs;
    dev_state    <= st;
    attr_rd_fail <= rf;
    attr_wr_fail <= wf;
    @(posedge sys_clk);
    cmd_valid <= 1'b0;
  endtask
  task automatic send_err(input int k);
    @(posedge sys_clk);
    err_valid <= 1'b1;
    {err_error, err_seccnt, err_secnum, err_cyllo, err_cylhi, err_devhead, err_status} <=
      {cb(k, 1), cb(k, 2), cb(k, 3), cb(k, 4), cb(k, 5), cb(k, 6), 8'(8'h70 + k)};
    power_on_hours <= 16'h1234 + 16'(k);
    @(posedge sys_clk);
    err_valid <= 1'b0;
  endtask
  task automatic read_sum(input logic sel, input bit slow);
    i_host.read_sector(sel, slow);
    s = 8'h00;
    for (int a = 0; a < 512; a++)
      s = s + i_host.sec[a];
    chk("checksum", s, 8'h00);
    chk("last_flag", i_host.last_at, 511);
  endtask
  task automatic final_report;
    $display("Comparisons %0d, mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // Hang guard, well above the few thousand cycles the tests need
  initial
  begin
    repeat (30000) @(posedge sys_clk);
    err_count++;
    final_report();
  end
  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial
  begin
    reset = 1'b1;
    {cmd_valid, err_valid, st_valid, attr_rd_fail, attr_wr_fail, dev_state, power_on_hours, st_lba} = '0;
    {cmd_devctl, cmd_feat, cmd_seccnt, cmd_secnum, cmd_cyllo, cmd_cylhi, cmd_devhead, cmd_code} = '0;
    {err_error, err_seccnt, err_secnum, err_cyllo, err_cylhi, err_devhead, err_status} = '0;
    {st_number, st_status, st_checkpoint} = '0;
    repeat (3) @(posedge sys_clk);
    reset <= 1'b0;
    #1;
    chk("after_reset", {smart_done, smart_enabled, rd_valid}, 3'b010);
    for (int i = 0; i < 17; i++)
    begin
      send_cmd({8'h00, rows[i].feat, 16'h0000, (rows[i].kb ? 8'h4e : 8'h4f), 16'hc2a0, 8'hb0}, 4'h3, rows[i].rf,
        rows[i].wf);
      #1;
      chk("reply", {smart_done, smart_status, smart_error, smart_enabled},
        {1'b1, rows[i].st, rows[i].er, rows[i].en});
    end
    // Mid-run reset must clear the logs and re-enable monitoring
    @(posedge sys_clk);
    reset <= 1'b1;
    repeat (3) @(posedge sys_clk);
    reset <= 1'b0;
    #1;
    chk("enabled_after_reset", smart_enabled, 1'b1);
    read_sum(1'b1, 1'b0);
    chk("st_empty", {i_host.sec[0], i_host.sec[1], i_host.sec[9'h1fc]}, 24'h010000);
    for (int k = 0; k < 7; k++)
    begin
      send_cmd(creg(k), sts[k], 1'b0, 1'b0);
      send_err(k);
      read_sum(1'b0, k[0]);
      base = 2 + 90 * (k % 5);
      chk("err_ptr", i_host.sec[1], k % 5 + 1);
      chk("err_count", {i_host.sec[9'h1c5], i_host.sec[9'h1c4]}, k + 1);
      for (int j = 0; j < 5; j++)
        for (int b = 0; b < 8; b++)
          chk("cmd_snap", i_host.sec[base + 12 * j + b], cb(k - 4 + j, b));
      for (int b = 0; b < 30; b++)
        chk("err_snap", i_host.sec[base + 60 + b], es(k, b));
    end
    // Two commands forty cycles apart must be stamped ten counts apart
    send_cmd(creg(7), 4'h3, 1'b0, 1'b0);
    repeat (38) @(posedge sys_clk);
    send_cmd(creg(8), 4'h3, 1'b0, 1'b0);
    send_err(8);
    read_sum(1'b0, 1'b0);
    chk("ms_step", ms_at(182 + 56) - ms_at(182 + 44), 32'd10);
    // Back-to-back self-test results, wrapping past the ring size
    for (int t = 0; t < 23; t++)
    begin
      @(posedge sys_clk);
      st_valid       <= 1'b1;
      st_number      <= 8'(t + 1);
      st_status      <= 8'(8'h10 + t);
      st_checkpoint  <= 8'(8'h80 + t);
      st_lba         <= 32'h0a0b0c00 + 32'(t);
      power_on_hours <= 16'h0100 + 16'(t);
      if (t == 20)
      begin
        @(posedge sys_clk);
        st_valid <= 1'b0;
        read_sum(1'b1, 1'b0);
        chk("st_ptr_full", i_host.sec[9'h1fc], 8'd21);
      end
    end
    @(posedge sys_clk);
    st_valid <= 1'b0;
    read_sum(1'b1, 1'b1);
    chk("st_ptr_wrap", i_host.sec[9'h1fc], 8'd2);
    for (int i = 0; i < 21; i++)
      for (int b = 0; b < 24; b++)
        chk("st_desc", i_host.sec[24 * i + 2 + b], sd((i < 2) ? i + 21 : i, b));
    for (int a = 9'h1fa; a < 9'h1ff; a++)
      if (a != 9'h1fc)
        chk("st_tail", i_host.sec[a], 8'h00);
    final_report();
  end
endmodule
`default_nettype wire
